// ===== lscp_pkg.sv
// package: register map, field positions and timing counts for the line slave config block
package lscp_pkg;
  localparam logic [7:0] CFG_OFFSET        = 8'h13;
  localparam logic [7:0] LOCKID_OFFSET     = 8'h14;
  localparam logic [7:0] STATUS_OFFSET     = 8'h18;
  localparam logic [7:0] IDEXT1_OFFSET     = 8'h19;
  localparam logic [7:0] CTRL_OFFSET       = 8'h1A;
  localparam logic [7:0] LEAD_OFFSET       = 8'h1B;
  localparam logic [7:0] THR_OFFSET        = 8'h1C;
  localparam int         CFG_SYNC_BIT      = 0;
  localparam int         CFG_PIN_GATE_BIT  = 1;
  localparam int         CFG_EXT4_BIT      = 2;
  localparam int         CFG_LOCK_BIT      = 3;
  localparam int         ID_AB_BIT         = 3;
  localparam logic [3:0] CFG_RESET         = 4'h0;
  localparam logic [3:0] LOCKID_RESET      = 4'h0;
  localparam logic [3:0] IDEXT1_RESET      = 4'hF;
  localparam logic [15:0] LEAD_RESET       = 16'h0064;
  localparam int         THR_PCT_NUM       = 1;
  localparam int         THR_PCT_DEN       = 2;
  localparam int         FILT_SHIFT        = 2;
  localparam int         AMP_W             = 8;

  // one-hot line control states
  typedef enum logic [3:0] {
    LSCP_IDLE = 4'h1,
    LSCP_RX   = 4'h2,
    LSCP_BIAS = 4'h4,
    LSCP_TX   = 4'h8
  } lscp_state_e;

  // register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } lscp_bus_s;
endpackage : lscp_pkg

// ===== lscp_core.sv
// line slave configuration bank with receiver threshold and rx/tx enable control
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module lscp_core #(
  parameter int AMP_W = lscp_pkg::AMP_W
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             clk_en,
  input  wire lscp_pkg::lscp_bus_s bus,
  output logic [15:0]           rdata,
  input  wire logic             parameter_pin_two,
  input  wire logic [AMP_W-1:0] line_amp,
  input  wire logic             line_pause,
  input  wire logic             id1_rd_req,
  output logic [3:0]            id1_rd_data,
  output logic                  id1_rd_valid,
  input  wire logic             tx_req,
  input  wire logic             tx_done,
  output logic                  rx_pulse,
  output logic                  rx_en,
  output logic                  tx_en,
  output logic                  bias_en,
  output logic                  sync_io_active,
  output logic                  ext_addr_four_in_four_out
);
  logic [3:0]       cfg_q;
  logic [3:0]       lockid_q;
  logic [3:0]       idext1_q;
  logic [15:0]      lead_q;
  logic [15:0]      lead_cnt_q;
  logic             p2_s1_q, p2_s2_q, pause_s1_q, pause_s2_q;
  logic [AMP_W-1:0] amp_s1_q, amp_s2_q;
  logic [AMP_W-1:0] filt_q, thr_q;
  logic             have_first_q, above_q;
  lscp_pkg::lscp_state_e st_q;
  logic             wr_ok, lock;
  logic [3:0]       id_wmask;
  logic [AMP_W-1:0] thr_d;

  assign wr_ok = bus.wr & clk_en;
  assign lock  = cfg_q[lscp_pkg::CFG_LOCK_BIT];

  // two-stage synchronisers for pin and analog-front-end inputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      p2_s1_q    <= 1'b0;
      p2_s2_q    <= 1'b0;
      pause_s1_q <= 1'b0;
      pause_s2_q <= 1'b0;
      amp_s1_q   <= '0;
      amp_s2_q   <= '0;
    end else if (clk_en) begin
      p2_s1_q    <= parameter_pin_two;
      p2_s2_q    <= p2_s1_q;
      pause_s1_q <= line_pause;
      pause_s2_q <= pause_s1_q;
      amp_s1_q   <= line_amp;
      amp_s2_q   <= amp_s1_q;
    end
  end

  // configuration and locked id cells
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q    <= lscp_pkg::CFG_RESET;
      lockid_q <= lscp_pkg::LOCKID_RESET;
      lead_q   <= lscp_pkg::LEAD_RESET;
    end else if (wr_ok) begin
      if (bus.addr == lscp_pkg::CFG_OFFSET) cfg_q <= bus.wdata[3:0];
      if (bus.addr == lscp_pkg::LOCKID_OFFSET) lockid_q <= bus.wdata[3:0];
      if (bus.addr == lscp_pkg::LEAD_OFFSET) lead_q <= bus.wdata;
    end
  end

  // write mask for the user id code: lock blocks all bits, or only 2..0 in extended mode
  always_comb begin
    id_wmask = 4'hF;
    if (lock) begin
      id_wmask = 4'h0;
      if (cfg_q[lscp_pkg::CFG_EXT4_BIT]) id_wmask[lscp_pkg::ID_AB_BIT] = 1'b1;
    end
  end

  // user-writable first extended id code
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      idext1_q <= lscp_pkg::IDEXT1_RESET;
    end else if (wr_ok && bus.addr == lscp_pkg::IDEXT1_OFFSET) begin
      idext1_q <= (idext1_q & ~id_wmask) | (bus.wdata[3:0] & id_wmask);
    end
  end

  // id code 1 read answer, locked cell substitutes the user value
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      id1_rd_data  <= 4'h0;
      id1_rd_valid <= 1'b0;
    end else if (clk_en) begin
      id1_rd_valid <= id1_rd_req;
      if (id1_rd_req) id1_rd_data <= lock ? lockid_q : idext1_q;
    end
  end

  // mode outputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync_io_active            <= 1'b0;
      ext_addr_four_in_four_out <= 1'b0;
    end else if (clk_en) begin
      sync_io_active <= cfg_q[lscp_pkg::CFG_SYNC_BIT] &
        (~cfg_q[lscp_pkg::CFG_PIN_GATE_BIT] | p2_s2_q);
      ext_addr_four_in_four_out <= cfg_q[lscp_pkg::CFG_EXT4_BIT];
    end
  end

  // threshold: half of filtered first amplitude
  assign thr_d = AMP_W'(filt_q * lscp_pkg::THR_PCT_NUM / lscp_pkg::THR_PCT_DEN);

  // first-pulse capture, filtering and comparator
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      filt_q       <= '0;
      thr_q        <= '0;
      have_first_q <= 1'b0;
      above_q      <= 1'b0;
      rx_pulse     <= 1'b0;
    end else if (clk_en) begin
      if (pause_s2_q || st_q != lscp_pkg::LSCP_RX) begin
        filt_q       <= '0;
        thr_q        <= '0;
        have_first_q <= 1'b0;
        above_q      <= 1'b0;
        rx_pulse     <= 1'b0;
      end else if (!have_first_q) begin
        if (amp_s2_q > filt_q) begin
          // rise tracked through a first-order filter, spikes move it only a little
          filt_q <= filt_q + AMP_W'((amp_s2_q - filt_q) >> lscp_pkg::FILT_SHIFT);
        end else if (filt_q != '0) begin
          have_first_q <= 1'b1;
          thr_q        <= thr_d;
        end
        rx_pulse <= 1'b0;
      end else begin
        above_q  <= amp_s2_q > thr_q;
        rx_pulse <= (amp_s2_q > thr_q) & ~above_q;
      end
    end
  end

  // rx/tx exclusive enable control with bias lead
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q       <= lscp_pkg::LSCP_RX;
      lead_cnt_q <= '0;
      rx_en      <= 1'b0;
      tx_en      <= 1'b0;
      bias_en    <= 1'b0;
    end else if (clk_en) begin
      case (st_q)
        lscp_pkg::LSCP_RX: begin
          if (tx_req) begin
            st_q       <= lscp_pkg::LSCP_BIAS;
            lead_cnt_q <= lead_q;
            rx_en      <= 1'b0;
            bias_en    <= 1'b1;
          end else begin
            rx_en <= 1'b1;
          end
          tx_en <= 1'b0;
        end
        lscp_pkg::LSCP_BIAS: begin
          if (lead_cnt_q <= 16'h0001) begin
            st_q  <= lscp_pkg::LSCP_TX;
            tx_en <= 1'b1;
          end else begin
            lead_cnt_q <= lead_cnt_q - 16'h0001;
          end
        end
        lscp_pkg::LSCP_TX: begin
          if (tx_done) begin
            st_q    <= lscp_pkg::LSCP_RX;
            tx_en   <= 1'b0;
            bias_en <= 1'b0;
          end
        end
        default: begin
          st_q    <= lscp_pkg::LSCP_RX;
          rx_en   <= 1'b0;
          tx_en   <= 1'b0;
          bias_en <= 1'b0;
        end
      endcase
    end
  end

  // register read data, one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (clk_en) begin
      rdata <= 16'h0000;
      if (bus.rd) begin
        case (bus.addr)
          lscp_pkg::CFG_OFFSET:    rdata <= {12'h000, cfg_q};
          lscp_pkg::LOCKID_OFFSET: rdata <= {12'h000, lockid_q};
          lscp_pkg::IDEXT1_OFFSET: rdata <= {12'h000, idext1_q};
          lscp_pkg::LEAD_OFFSET:   rdata <= lead_q;
          lscp_pkg::STATUS_OFFSET: rdata <= {10'h000, have_first_q, bias_en, tx_en, rx_en,
                                             ext_addr_four_in_four_out, sync_io_active};
          lscp_pkg::THR_OFFSET:    rdata <= 16'(thr_q);
          default:                 rdata <= 16'h0000;
        endcase
      end
    end
  end

  // never both line ends enabled
  rx_tx_excl_a: assert property (@(posedge sys_clk) disable iff (!rstn) !(rx_en && tx_en))
    else $error("rx and tx enabled together");
  tx_no_rx_a: assert property (@(posedge sys_clk) disable iff (!rstn) tx_en |-> !rx_en)
    else $error("receiver on while transmitting");

  // bias current leads the transmitter and stays on while it drives
  bias_lead_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(tx_en) |-> bias_en && $past(bias_en))
    else $error("tx enabled without bias lead");
  bias_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    tx_en |-> bias_en)
    else $error("tx enabled without bias current");
  bias_first_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(bias_en) |-> !tx_en)
    else $error("bias and tx raised together");

  // id code write protection and the id read answer
  lock_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wr_ok && bus.addr == lscp_pkg::IDEXT1_OFFSET && lock && !cfg_q[2])
      |=> $stable(idext1_q))
    else $error("locked id code changed");
  ab_bit_free_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wr_ok && bus.addr == lscp_pkg::IDEXT1_OFFSET && lock && cfg_q[2])
      |=> idext1_q[3] == $past(bus.wdata[3]) && idext1_q[2:0] == $past(idext1_q[2:0]))
    else $error("extended mode lock mask wrong");
  id_answer_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && id1_rd_req && lock) |=> id1_rd_valid && id1_rd_data == $past(lockid_q))
    else $error("id read not from locked cell");
  id_user_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && id1_rd_req && !lock) |=> id1_rd_valid && id1_rd_data == $past(idext1_q))
    else $error("id read not from user cell");

  // mode outputs follow the configuration cell and the pin
  sync_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && cfg_q[1:0] == 2'b11 && !p2_s2_q) |=> !sync_io_active)
    else $error("pin gating ignored");
  sync_pin_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && cfg_q[1:0] == 2'b11 && p2_s2_q) |=> sync_io_active)
    else $error("pin high did not activate sync io");
  sync_en_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && cfg_q[1:0] == 2'b01) |=> sync_io_active)
    else $error("sync io not enabled");
  sync_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && !cfg_q[0]) |=> !sync_io_active)
    else $error("sync io active while disabled");
  ext4_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en |=> ext_addr_four_in_four_out == $past(cfg_q[2]))
    else $error("ext mode output wrong");

  // receiver pulses, threshold capture and pause clearing
  pulse_short_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && rx_pulse) |=> !rx_pulse)
    else $error("receiver pulse longer than one cycle");
  thr_half_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(have_first_q) |-> thr_q == AMP_W'($past(filt_q) >> 1))
    else $error("threshold not half amplitude");
  thr_steady_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && have_first_q) |=> !have_first_q || thr_q == $past(thr_q))
    else $error("captured threshold moved");
  pause_clr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && pause_s2_q) |=> thr_q == '0 && !rx_pulse)
    else $error("pause did not clear threshold");

  // low clock enable freezes state, read data stand only after a read strobe
  frozen_state_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !clk_en |=> $stable(cfg_q) && $stable(st_q) && $stable(rdata) && $stable(filt_q))
    else $error("state moved while clock enable low");
  rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && !bus.rd) |=> rdata == 16'h0000)
    else $error("read data without read strobe");
endmodule : lscp_core
`default_nettype wire

// ===== lscp_line_model.sv
// line-side partner: amplitude samples and pause level seen by the receiver
`timescale 1ns/1ns
`default_nettype none
module lscp_line_model (
  input  wire logic       sys_clk,
  output logic [7:0]      line_amp,
  output logic            line_pause
);
  // quiet line: no signal and no pause at start
  initial begin
    line_amp   = 8'h00;
    line_pause = 1'b0;
  end

  // one sin2-like pulse: rise to amp, hold, then back to the zero dc level
  task automatic pulse(input logic [7:0] amp, input int hold);
    @(posedge sys_clk) line_amp <= amp;
    repeat (hold) @(posedge sys_clk);
    line_amp <= 8'h00;
    repeat (4) @(posedge sys_clk);
  endtask : pulse

  // telegram pause: long enough to pass the receiver's pause synchroniser
  task automatic pause();
    @(posedge sys_clk) line_pause <= 1'b1;
    repeat (4) @(posedge sys_clk);
    line_pause <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : pause
endmodule : lscp_line_model
`default_nettype wire

// ===== lscp_core_tb.sv
// self-checking bench for the line slave config and line control block
`timescale 1ns/1ns
`default_nettype none
module lscp_core_tb;
  logic                sys_clk;
  logic                rstn;
  logic                clk_en;
  lscp_pkg::lscp_bus_s bus;
  logic [15:0]         rdata;
  logic                pin2;
  logic [7:0]          line_amp;
  logic                line_pause;
  logic                id_req;
  logic [3:0]          id_data;
  logic                id_valid;
  logic                tx_req;
  logic                tx_done;
  logic                rx_pulse;
  logic                rx_en;
  logic                tx_en;
  logic                bias_en;
  logic                sync_act;
  logic                ext4;
  int                  err_count;
  int                  num_checks;
  int                  pulses;

  lscp_core i_dut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .bus(bus), .rdata(rdata),
    .parameter_pin_two(pin2), .line_amp(line_amp), .line_pause(line_pause),
    .id1_rd_req(id_req), .id1_rd_data(id_data), .id1_rd_valid(id_valid), .tx_req(tx_req),
    .tx_done(tx_done), .rx_pulse(rx_pulse), .rx_en(rx_en), .tx_en(tx_en), .bias_en(bias_en),
    .sync_io_active(sync_act), .ext_addr_four_in_four_out(ext4));
  lscp_line_model i_line (.sys_clk(sys_clk), .line_amp(line_amp), .line_pause(line_pause));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // count receiver output pulses and watch the rx/tx exclusion
  always @(posedge sys_clk) begin
    if (rx_pulse === 1'b1) pulses <= pulses + 1;
    if (rx_en === 1'b1 && tx_en === 1'b1) chk("rx_tx_both", 0, 1);
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk) bus.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk) bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk) bus.rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask : rd_chk

  task automatic id_chk(input logic [3:0] e);
    @(posedge sys_clk) id_req <= 1'b1;
    @(posedge sys_clk) id_req <= 1'b0;
    #1 chk("id_valid", 1, id_valid);
    chk("id_data", e, id_data);
  endtask : id_chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic t_regs();
    rd_chk("cfg_rst", 8'h13, 16'h0000);
    rd_chk("lockid_rst", 8'h14, 16'h0000);
    rd_chk("idext1_rst", 8'h19, 16'h000F);
    rd_chk("lead_rst", 8'h1B, 16'h0064);
    rd_chk("unmapped", 8'h1A, 16'h0000);
    $display("test regs done");
  endtask : t_regs

  // low clock enable: a write must not land while frozen
  task automatic t_freeze();
    @(posedge sys_clk) clk_en <= 1'b0;
    wr(8'h13, 16'h0001);
    @(posedge sys_clk) clk_en <= 1'b1;
    rd_chk("cfg_frozen", 8'h13, 16'h0000);
    $display("test freeze done");
  endtask : t_freeze

  task automatic t_modes();
    logic [3:0] cf[5] = '{4'h1, 4'h3, 4'h3, 4'h2, 4'h0};
    logic       pn[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic       ex[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk) pin2 <= pn[i];
      wr(8'h13, {12'h000, cf[i]});
      repeat (5) @(posedge sys_clk);
      #1 chk("sync_io_active", {15'h0, ex[i]}, {15'h0, sync_act});
    end
    wr(8'h13, 16'h0004);
    repeat (2) @(posedge sys_clk);
    #1 chk("ext4", 1, ext4);
    $display("test modes done");
  endtask : t_modes

  task automatic t_lock();
    wr(8'h13, 16'h0000);
    wr(8'h19, 16'h0005);
    wr(8'h14, 16'h000A);
    id_chk(4'h5);
    wr(8'h13, 16'h0008);
    id_chk(4'hA);
    wr(8'h19, 16'h0002);
    rd_chk("idext1_locked", 8'h19, 16'h0005);
    wr(8'h13, 16'h000C);
    wr(8'h19, 16'h000A);
    rd_chk("idext1_ext", 8'h19, 16'h000D);
    $display("test lock done");
  endtask : t_lock

  task automatic t_rx();
    int p0;
    logic [7:0] thr;
    i_line.pause();
    i_line.pulse(8'hC8, 24);
    @(posedge sys_clk) bus <= '{addr: 8'h1C, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk) bus.rd <= 1'b0;
    #1 thr = rdata[7:0];
    chk("thr_range", 1, {15'h0, (thr >= 8'd90 && thr <= 8'd110)});
    p0 = pulses;
    i_line.pulse(8'hFF, 1);
    i_line.pulse(8'h96, 4);
    i_line.pulse(8'h3C, 4);
    repeat (3) @(posedge sys_clk);
    chk("rx_pulses", 2, 16'(pulses - p0));
    rd_chk("thr_after_spike", 8'h1C, {8'h00, thr});
    i_line.pause();
    rd_chk("thr_cleared", 8'h1C, 16'h0000);
    $display("test rx done");
  endtask : t_rx

  task automatic t_tx(input int lead);
    int n;
    wr(8'h1B, 16'(lead));
    @(posedge sys_clk) tx_req <= 1'b1;
    @(posedge sys_clk) tx_req <= 1'b0;
    #1 chk("bias_on", 1, bias_en);
    chk("rx_off", 0, rx_en);
    n = 0;
    while (tx_en !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n >= 300) begin
      err_count++;
      end_of_test();
    end else begin
      chk("bias_lead", 16'(lead), 16'(n));
      rd_chk("status_tx", 8'h18, 16'h001A);
      @(posedge sys_clk) tx_done <= 1'b1;
      @(posedge sys_clk) tx_done <= 1'b0;
      #1 chk("tx_off", 0, {tx_en, bias_en});
      @(posedge sys_clk);
      #1 chk("rx_back", 1, rx_en);
      $display("test tx lead %0d done", lead);
    end
  endtask : t_tx

  // main sequence
  initial begin
    err_count  = 0;
    num_checks = 0;
    pulses     = 0;
    rstn       = 1'b0;
    clk_en     = 1'b1;
    bus        = '0;
    pin2       = 1'b0;
    id_req     = 1'b0;
    tx_req     = 1'b0;
    tx_done    = 1'b0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_regs();
    t_freeze();
    t_modes();
    t_lock();
    t_rx();
    t_tx(2);
    t_tx(7);
    end_of_test();
  end
endmodule : lscp_core_tb
`default_nettype wire
